/* File: hdl/mode_guard_pkg.sv */
// constants for the cpu mode controller and memory partition guard
// assumes a byte-addressed 24-bit fetch/data space shared by rom, eeprom and ram windows
package mode_guard_pkg;

	typedef enum logic [2:0] {
		MODE_BOOT = 3'h0,
		MODE_TEST = 3'h1,
		MODE_SYSTEM = 3'h3,
		MODE_USER = 3'h2,
		MODE_CLFW = 3'h6
	} cpu_mode_e;

	typedef enum logic [1:0] {
		EMU_NONE = 2'h0,
		EMU_ONE_K = 2'h1,
		EMU_FOUR_K = 2'h3
	} emu_option_e;

	localparam int ADDR_W = 24;

	// rom: application part first, test part on top
	localparam logic [23:0] ROM_BASE = 24'h000000;
	localparam logic [23:0] ROM_APP_SIZE = 24'h042000;
	localparam logic [23:0] ROM_TEST_SIZE = 24'h006000;
	localparam logic [23:0] ROM_TEST_BASE = ROM_BASE + ROM_APP_SIZE;
	localparam logic [23:0] ROM_END = ROM_TEST_BASE + ROM_TEST_SIZE;

	// eeprom: manufacturer bytes, then firmware part, then application
	localparam logic [23:0] EE_BASE = 24'h080000;
	localparam logic [23:0] EE_SIZE = 24'h024000;
	localparam logic [23:0] EE_MFG_SIZE = 24'h000080;
	localparam logic [23:0] EE_FW_ONE_K = 24'h000400;
	localparam logic [23:0] EE_FW_FOUR_K = 24'h001000;
	localparam logic [23:0] EE_END = EE_BASE + EE_SIZE;

	// ram: firmware part first, then general purpose, then coprocessor part
	localparam logic [23:0] RAM_BASE = 24'h0C0000;
	localparam logic [23:0] RAM_SIZE = 24'h001E00;
	localparam logic [23:0] RAM_FW_SIZE = 24'h000080;
	localparam logic [23:0] RAM_COP_SIZE = 24'h000A00;
	localparam logic [23:0] RAM_END = RAM_BASE + RAM_SIZE;
	localparam logic [23:0] RAM_COP_BASE = RAM_END - RAM_COP_SIZE;

	// exception and interrupt vectors sit at the bottom of application rom, 8 bytes apart
	localparam int NUM_EVENTS = 16;
	localparam logic [23:0] EVENT_VEC_BASE = 24'h000000;
	localparam logic [23:0] VEC_STRIDE = 24'h000008;
	localparam logic [NUM_EVENTS-1:0] EVENT_TO_USER = 16'h0000;

	localparam int NUM_CFG_VEC = 8;
	localparam logic [23:0] CFG_VEC_BASE = 24'h000100;
	localparam int NUM_SYS_VEC = 32;
	localparam logic [23:0] SYS_VEC_BASE = 24'h000200;

	// number of hardware components that user mode may be granted
	localparam int NUM_UNITS = 8;
	localparam int NUM_USER_WIN = 4;

endpackage

/* File: hdl/cpu_mode_memory_guard.sv */
// cpu mode controller and memory partition guard
// assumes the core presents one fetch/data request per cycle and waits on grant;
// the test-disable fuse and emulation option are static straps after production
// Behaviour
// - five modes, three firmware sub-modes
// - internal selector picks the firmware sub-mode
// - reset ends in test before fuse
// - blown fuse keeps test mode unreachable
// - after fuse, reset ends in system
// - system mode reaches every unit
// - user mode reaches only granted units and cpu registers
// - events jump to vector, set mode
// - eight config vectors force firmware mode
// - 32 syscall vectors force system mode
// - rom split into application and test
// - eeprom reserves maker and firmware bytes
// - ram reserves 0 or 128 firmware bytes
// - test mode reaches all memory
// - firmware modes other than test reach only reserved regions
// - system, user reach application; user filtered
// - coprocessor reaches only its ram part and application eeprom
// - coprocessor eeprom access is checked against the application part
`timescale 1ns/10ps
`default_nettype none
module cpu_mode_memory_guard
	import mode_guard_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic test_disabled_fuse,
	input wire mode_guard_pkg::emu_option_e emu_option,
	input wire logic boot_done,
	input wire logic [1:0] fw_select,
	input wire logic fw_select_wr,
	input wire logic [NUM_EVENTS-1:0] event_req,
	input wire logic jump_valid,
	input wire logic [23:0] jump_target,
	input wire logic return_to_user,
	input wire logic [NUM_UNITS-1:0] unit_grant_wr_data,
	input wire logic unit_grant_wr,
	input wire logic [23:0] user_win_lo,
	input wire logic [23:0] user_win_hi,
	input wire logic [1:0] user_win_idx,
	input wire logic user_win_wr,
	input wire logic sfr_req,
	input wire logic [2:0] sfr_unit,
	input wire logic sfr_is_cpu,
	input wire logic mem_req,
	input wire logic [23:0] mem_addr,
	input wire logic cop_req,
	input wire logic [23:0] cop_addr,
	output var mode_guard_pkg::cpu_mode_e cpu_mode,
	output logic vector_load,
	output logic [23:0] vector_addr,
	output logic mem_grant,
	output logic sfr_grant,
	output logic cop_grant,
	output logic violation
);
	import mode_guard_pkg::*;

	logic fuse_q;
	logic [NUM_UNITS-1:0] unit_grant;
	logic [23:0] win_lo [NUM_USER_WIN];
	logic [23:0] win_hi [NUM_USER_WIN];
	logic [NUM_USER_WIN-1:0] win_hit;
	logic [3:0] event_idx;
	logic event_any;
	logic is_cfg_vec;
	logic is_sys_vec;
	logic [23:0] ee_fw_size;
	logic [23:0] ram_fw_size;
	logic in_rom_app, in_rom_test, in_ee_mfg, in_ee_fw, in_ee_app;
	logic in_ram_fw, in_ram_app, in_cop_ram;
	logic next_mem_ok;
	logic next_sfr_ok;
	logic next_cop_ok;
	cpu_mode_e next_mode;
	cpu_mode_e sub_mode;

	// fuse forced blown by the async branch, strap captured on each edge after reset release
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fuse_q <= 1'b1;
		end else begin
			fuse_q <= test_disabled_fuse;
		end
	end

	// test selection dropped once fuse blown
	// written value decoded at once, so a selector write lands on the next edge like any mode change
	always_comb begin
		case (fw_select)
			2'h1: sub_mode = fuse_q ? MODE_BOOT : MODE_TEST;
			2'h2: sub_mode = MODE_CLFW;
			default: sub_mode = MODE_BOOT;
		endcase
	end

	always_comb begin
		event_idx = 4'h0;
		event_any = 1'b0;
		for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
			if (event_req[i]) begin
				event_idx = 4'(i);
				event_any = 1'b1;
			end
		end
	end

	assign is_cfg_vec = jump_target >= CFG_VEC_BASE && jump_target < CFG_VEC_BASE + VEC_STRIDE * 24'(NUM_CFG_VEC);
	assign is_sys_vec = jump_target >= SYS_VEC_BASE && jump_target < SYS_VEC_BASE + VEC_STRIDE * 24'(NUM_SYS_VEC);

	// mode transitions among the five modes
	always_comb begin
		next_mode = cpu_mode;
		case (cpu_mode)
			MODE_BOOT, MODE_TEST: begin
				// boot ends in test before fuse
				// boot ends in system after fuse
				if (boot_done) begin
					next_mode = fuse_q ? MODE_SYSTEM : MODE_TEST;
				end
			end
			MODE_CLFW: begin
				if (return_to_user) begin
					next_mode = MODE_SYSTEM;
				end
			end
			MODE_SYSTEM: begin
				if (return_to_user) begin
					next_mode = MODE_USER;
				end
			end
			MODE_USER: begin
			end
			default: next_mode = MODE_BOOT;
		endcase
		if (cpu_mode != MODE_BOOT && cpu_mode != MODE_TEST) begin
			if (event_any) begin
				next_mode = EVENT_TO_USER[event_idx] ? MODE_USER : MODE_SYSTEM;
			end else if (jump_valid && is_cfg_vec) begin
				next_mode = MODE_CLFW;
			end else if (jump_valid && is_sys_vec) begin
				next_mode = MODE_SYSTEM;
			end
		end
		// selector honoured only in boot and test; a fuse-blown boot exit wins
		if (fw_select_wr && (cpu_mode == MODE_BOOT || cpu_mode == MODE_TEST) && next_mode != MODE_SYSTEM) begin
			next_mode = sub_mode;
		end
	end

	// reset always starts in boot; boot completion then picks test or system
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cpu_mode <= MODE_BOOT;
		end else begin
			cpu_mode <= next_mode;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			vector_load <= 1'b0;
			vector_addr <= 24'h000000;
		end else begin
			vector_load <= event_any && cpu_mode != MODE_BOOT && cpu_mode != MODE_TEST;
			vector_addr <= EVENT_VEC_BASE + VEC_STRIDE * {20'h00000, event_idx};
		end
	end

	// grants written only from system mode
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			unit_grant <= '0;
		end else if (unit_grant_wr && cpu_mode == MODE_SYSTEM) begin
			unit_grant <= unit_grant_wr_data;
		end
	end

	// per-window user filter, empty at reset
	generate
		for (genvar w = 0; w < NUM_USER_WIN; w++) begin : g_win
			always_ff @(posedge core_clk or posedge reset) begin
				if (reset) begin
					win_lo[w] <= 24'hFFFFFF;
					win_hi[w] <= 24'h000000;
				end else if (user_win_wr && cpu_mode == MODE_SYSTEM && user_win_idx == 2'(w)) begin
					win_lo[w] <= user_win_lo;
					win_hi[w] <= user_win_hi;
				end
			end
			assign win_hit[w] = mem_addr >= win_lo[w] && mem_addr <= win_hi[w];
		end
	endgenerate

	always_comb begin
		case (emu_option)
			EMU_ONE_K: ee_fw_size = EE_FW_ONE_K;
			EMU_FOUR_K: ee_fw_size = EE_FW_FOUR_K;
			default: ee_fw_size = 24'h000000;
		endcase
	end
	assign ram_fw_size = emu_option == EMU_NONE ? 24'h000000 : RAM_FW_SIZE;

	assign in_rom_app = mem_addr >= ROM_BASE && mem_addr < ROM_TEST_BASE;
	assign in_rom_test = mem_addr >= ROM_TEST_BASE && mem_addr < ROM_END;
	assign in_ee_mfg = mem_addr >= EE_BASE && mem_addr < EE_BASE + EE_MFG_SIZE;
	assign in_ee_fw = mem_addr >= EE_BASE + EE_MFG_SIZE && mem_addr < EE_BASE + EE_MFG_SIZE + ee_fw_size;
	assign in_ee_app = mem_addr >= EE_BASE + EE_MFG_SIZE + ee_fw_size && mem_addr < EE_END;
	assign in_ram_fw = mem_addr >= RAM_BASE && mem_addr < RAM_BASE + ram_fw_size;
	assign in_ram_app = mem_addr >= RAM_BASE + ram_fw_size && mem_addr < RAM_END;
	assign in_cop_ram = cop_addr >= RAM_COP_BASE && cop_addr < RAM_END;

	always_comb begin
		case (cpu_mode)
			MODE_TEST: next_mem_ok = 1'b1;
			MODE_BOOT, MODE_CLFW: next_mem_ok = in_rom_test || in_ee_mfg || in_ee_fw || in_ram_fw;
			MODE_SYSTEM: next_mem_ok = in_rom_app || in_ee_app || in_ram_app;
			MODE_USER: next_mem_ok = (in_rom_app || in_ee_app || in_ram_app) && |win_hit;
			default: next_mem_ok = 1'b0;
		endcase
	end

	assign next_sfr_ok = cpu_mode != MODE_USER || sfr_is_cpu || unit_grant[sfr_unit];

	assign next_cop_ok = in_cop_ram || (cop_addr >= EE_BASE + EE_MFG_SIZE + ee_fw_size && cop_addr < EE_END);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mem_grant <= 1'b0;
			sfr_grant <= 1'b0;
			cop_grant <= 1'b0;
			violation <= 1'b0;
		end else begin
			mem_grant <= mem_req && next_mem_ok;
			sfr_grant <= sfr_req && next_sfr_ok;
			cop_grant <= cop_req && next_cop_ok;
			violation <= (mem_req && !next_mem_ok) || (sfr_req && !next_sfr_ok);
		end
	end

	property p_test_blocked;
		@(posedge core_clk) disable iff (reset) fuse_q |-> cpu_mode != MODE_TEST;
	endproperty
	a_test_blocked: assert property (p_test_blocked) else $error("test mode with fuse blown");

	property p_boot_exit;
		@(posedge core_clk) disable iff (reset)
			(cpu_mode == MODE_BOOT && boot_done && !fw_select_wr) |=> cpu_mode == ($past(fuse_q) ? MODE_SYSTEM : MODE_TEST);
	endproperty
	a_boot_exit: assert property (p_boot_exit) else $error("wrong mode after boot");

	property p_sel_fw;
		@(posedge core_clk) disable iff (reset)
			(cpu_mode == MODE_TEST && fw_select_wr && fw_select == 2'h2 && !boot_done) |=> cpu_mode == MODE_CLFW;
	endproperty
	a_sel_fw: assert property (p_sel_fw) else $error("selector write missed firmware mode");

	property p_sys_vec;
		@(posedge core_clk) disable iff (reset)
			(cpu_mode == MODE_USER && !event_any && jump_valid && is_sys_vec) |=> cpu_mode == MODE_SYSTEM;
	endproperty
	a_sys_vec: assert property (p_sys_vec) else $error("syscall did not enter system");

	property p_cfg_vec;
		@(posedge core_clk) disable iff (reset)
			(cpu_mode == MODE_SYSTEM && !event_any && jump_valid && is_cfg_vec) |=> cpu_mode == MODE_CLFW;
	endproperty
	a_cfg_vec: assert property (p_cfg_vec) else $error("config vector did not enter firmware");

	property p_event_vec;
		@(posedge core_clk) disable iff (reset)
			(event_any && cpu_mode == MODE_USER) |=> vector_load && cpu_mode == MODE_SYSTEM;
	endproperty
	a_event_vec: assert property (p_event_vec) else $error("event missed vector");

	property p_violation;
		@(posedge core_clk) disable iff (reset) mem_req ##1 violation |-> !mem_grant;
	endproperty
	a_violation: assert property (p_violation) else $error("granted and flagged together");

	property p_user_testrom;
		@(posedge core_clk) disable iff (reset) (cpu_mode == MODE_USER && in_rom_test && mem_req) |=> !mem_grant;
	endproperty
	a_user_testrom: assert property (p_user_testrom) else $error("user reached test rom");

	property p_fw_ram;
		@(posedge core_clk) disable iff (reset) (cpu_mode == MODE_CLFW && in_ram_app && mem_req) |=> violation;
	endproperty
	a_fw_ram: assert property (p_fw_ram) else $error("firmware reached application ram");
endmodule
`default_nettype wire

/* File: dv/core_model.sv */
// cpu core stand-in: fetches, data accesses, jumps and coprocessor accesses
// assumes the guard answers one cycle after the request edge
`timescale 1ns/10ps
`default_nettype none
module core_model (
	input wire logic core_clk,
	input wire logic mem_grant,
	input wire logic violation,
	input wire logic cop_grant,
	output logic mem_req,
	output logic [23:0] mem_addr,
	output logic jump_valid,
	output logic [23:0] jump_target,
	output logic cop_req,
	output logic [23:0] cop_addr
);
	initial begin
		mem_req = 1'b0;
		mem_addr = 24'h0;
		jump_valid = 1'b0;
		jump_target = 24'h0;
		cop_req = 1'b0;
		cop_addr = 24'h0;
	end
	// k: 0 memory, 1 jump, 2 coprocessor; released addresses are inverted so a stale value cannot pass
	task automatic req(input int k, input logic [23:0] a, output logic g, output logic v);
		@(posedge core_clk);
		mem_req <= k == 0;
		jump_valid <= k == 1;
		cop_req <= k == 2;
		mem_addr <= a;
		jump_target <= a;
		cop_addr <= a;
		@(posedge core_clk);
		mem_req <= 1'b0;
		jump_valid <= 1'b0;
		cop_req <= 1'b0;
		mem_addr <= ~a;
		jump_target <= ~a;
		cop_addr <= ~a;
		#1;
		g = k == 2 ? cop_grant : mem_grant;
		v = violation;
	endtask
endmodule
`default_nettype wire

/* File: dv/cpu_mode_memory_guard_bench.sv */
// self-checking bench for the cpu mode controller and memory guard
// assumes core_model stands in for the cpu core
`timescale 1ns/10ps
`default_nettype none
module cpu_mode_memory_guard_bench;
	import mode_guard_pkg::*;
	logic core_clk;
	logic reset = 1'b1;
	logic test_disabled_fuse = 1'b1;
	emu_option_e emu_option = EMU_ONE_K;
	logic boot_done = 1'b0;
	logic [1:0] fw_select = 2'h0;
	logic fw_select_wr = 1'b0;
	logic [1:0] user_win_idx = 2'h0;
	logic [15:0] event_req = 16'h0;
	logic return_to_user = 1'b0;
	logic [7:0] unit_grant_wr_data = 8'h0;
	logic unit_grant_wr = 1'b0;
	logic [23:0] user_win_lo = 24'h0;
	logic [23:0] user_win_hi = 24'h0;
	logic user_win_wr = 1'b0;
	logic sfr_req = 1'b0;
	logic [2:0] sfr_unit = 3'h0;
	logic sfr_is_cpu = 1'b0;
	logic mem_req;
	logic [23:0] mem_addr;
	logic jump_valid;
	logic [23:0] jump_target;
	logic cop_req;
	logic [23:0] cop_addr;
	cpu_mode_e cpu_mode;
	logic vector_load;
	logic [23:0] vector_addr;
	logic mem_grant;
	logic sfr_grant;
	logic cop_grant;
	logic violation;
	int bad_count = 0;
	int n_checks = 0;

	cpu_mode_memory_guard dut (.core_clk, .reset, .test_disabled_fuse, .emu_option, .boot_done,
		.fw_select, .fw_select_wr, .event_req, .jump_valid, .jump_target, .return_to_user,
		.unit_grant_wr_data, .unit_grant_wr, .user_win_lo, .user_win_hi, .user_win_idx,
		.user_win_wr, .sfr_req, .sfr_unit, .sfr_is_cpu, .mem_req, .mem_addr, .cop_req, .cop_addr,
		.cpu_mode, .vector_load, .vector_addr, .mem_grant, .sfr_grant, .cop_grant, .violation);
	core_model core (.core_clk, .mem_grant, .violation, .cop_grant, .mem_req, .mem_addr,
		.jump_valid, .jump_target, .cop_req, .cop_addr);

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// k: 0 leave boot, 1 return, 2 unit grant write, 3 window write
	task automatic pulse(input int k);
		@(posedge core_clk);
		boot_done <= k == 0;
		return_to_user <= k == 1;
		unit_grant_wr <= k == 2;
		user_win_wr <= k == 3;
		@(posedge core_clk);
		boot_done <= 1'b0;
		return_to_user <= 1'b0;
		unit_grant_wr <= 1'b0;
		user_win_wr <= 1'b0;
		#1;
	endtask
	task automatic acc(input int k, input logic [23:0] a, input logic ok);
		logic g;
		logic v;
		core.req(k, a, g, v);
		if (k == 2) begin
			chk({23'h0, g}, {23'h0, ok});
		end else begin
			chk({22'h0, g, v}, {22'h0, ok, ~ok});
		end
	endtask
	task automatic jump_to(input logic [23:0] a, input cpu_mode_e m);
		logic g;
		logic v;
		core.req(1, a, g, v);
		chk(24'(cpu_mode), 24'(m));
	endtask
	task automatic sfr(input logic [2:0] u, input logic c, input logic ok);
		@(posedge core_clk);
		sfr_req <= 1'b1;
		sfr_unit <= u;
		sfr_is_cpu <= c;
		@(posedge core_clk);
		sfr_req <= 1'b0;
		#1;
		chk({22'h0, sfr_grant, violation}, {22'h0, ok, ~ok});
	endtask
	// selector write, held over one sampling edge
	task automatic sel(input logic [1:0] s);
		@(posedge core_clk);
		fw_select <= s;
		fw_select_wr <= 1'b1;
		@(posedge core_clk);
		fw_select_wr <= 1'b0;
		#1;
	endtask
	task automatic t_start(input logic f, input emu_option_e e, input cpu_mode_e m);
		@(posedge core_clk);
		reset <= 1'b1;
		test_disabled_fuse <= f;
		emu_option <= e;
		repeat (20) @(posedge core_clk);
		#1;
		chk(24'(cpu_mode), 24'(MODE_BOOT));
		@(posedge core_clk);
		reset <= 1'b0;
		sel(2'h1);
		chk(24'(cpu_mode), 24'(f ? MODE_BOOT : MODE_TEST));
		pulse(0);
		chk(24'(cpu_mode), 24'(m));
	endtask
	task automatic t_system();
		acc(0, ROM_TEST_BASE - 24'h1, 1'b1);
		acc(0, ROM_TEST_BASE, 1'b0);
		acc(0, RAM_BASE + RAM_FW_SIZE - 24'h1, 1'b0);
		acc(0, RAM_BASE + RAM_FW_SIZE, 1'b1);
		acc(0, EE_BASE + EE_MFG_SIZE, 1'b0);
		acc(0, EE_BASE + EE_MFG_SIZE + EE_FW_ONE_K, 1'b1);
		sfr(3'h5, 1'b0, 1'b1);
	endtask
	task automatic t_user();
		@(posedge core_clk);
		unit_grant_wr_data <= 8'h04;
		user_win_lo <= 24'h001000;
		user_win_hi <= 24'h001FFF;
		pulse(2);
		pulse(3);
		@(posedge core_clk);
		user_win_idx <= 2'h3;
		user_win_lo <= 24'h002000;
		user_win_hi <= 24'h0020FF;
		pulse(3);
		pulse(1);
		chk(24'(cpu_mode), 24'(MODE_USER));
		sfr(3'h2, 1'b0, 1'b1);
		sfr(3'h5, 1'b0, 1'b0);
		sfr(3'h5, 1'b1, 1'b1);
		acc(0, 24'h001800, 1'b1);
		acc(0, 24'h002080, 1'b1);
		acc(0, 24'h003000, 1'b0);
		acc(0, ROM_TEST_BASE, 1'b0);
		acc(2, RAM_COP_BASE, 1'b1);
		acc(2, RAM_COP_BASE - 24'h1, 1'b0);
		acc(2, EE_END - 24'h10, 1'b1);
		jump_to(24'h010000, MODE_USER);
		jump_to(SYS_VEC_BASE + 24'(NUM_SYS_VEC) * VEC_STRIDE, MODE_USER);
		// two sources at once: the lower index must win
		@(posedge core_clk);
		event_req <= 16'h0028;
		@(posedge core_clk);
		event_req <= 16'h0;
		#1;
		chk({23'h0, vector_load}, 24'h1);
		chk(vector_addr, EVENT_VEC_BASE + 24'h3 * VEC_STRIDE);
		chk(24'(cpu_mode), 24'(MODE_SYSTEM));
	endtask
	task automatic t_vectors();
		for (int i = 0; i < NUM_SYS_VEC; i++) begin
			pulse(1);
			jump_to(SYS_VEC_BASE + 24'(i) * VEC_STRIDE, MODE_SYSTEM);
		end
		for (int i = 0; i < NUM_CFG_VEC; i++) begin
			jump_to(CFG_VEC_BASE + 24'(i) * VEC_STRIDE, MODE_CLFW);
			pulse(1);
		end
		jump_to(CFG_VEC_BASE + 24'(NUM_CFG_VEC) * VEC_STRIDE, MODE_SYSTEM);
		jump_to(CFG_VEC_BASE, MODE_CLFW);
		acc(0, ROM_TEST_BASE, 1'b1);
		acc(0, ROM_TEST_BASE - 24'h1, 1'b0);
		acc(0, RAM_BASE, 1'b1);
		acc(0, EE_BASE + EE_MFG_SIZE, 1'b1);
		acc(0, RAM_BASE + RAM_FW_SIZE, 1'b0);
	endtask
	task automatic t_options();
		t_start(1'b1, EMU_FOUR_K, MODE_SYSTEM);
		acc(0, EE_BASE + EE_MFG_SIZE + EE_FW_FOUR_K - 24'h1, 1'b0);
		acc(0, EE_BASE + EE_MFG_SIZE + EE_FW_FOUR_K, 1'b1);
		t_start(1'b1, EMU_NONE, MODE_SYSTEM);
		acc(0, RAM_BASE, 1'b1);
		acc(0, EE_BASE + EE_MFG_SIZE, 1'b1);
		acc(0, EE_BASE, 1'b0);
	endtask
	task automatic t_test();
		t_start(1'b0, EMU_ONE_K, MODE_TEST);
		acc(0, ROM_TEST_BASE, 1'b1);
		acc(0, 24'h010000, 1'b1);
		acc(0, RAM_BASE, 1'b1);
		acc(0, EE_BASE, 1'b1);
		sel(2'h2);
		chk(24'(cpu_mode), 24'(MODE_CLFW));
		// selector is locked once firmware mode runs
		sel(2'h1);
		chk(24'(cpu_mode), 24'(MODE_CLFW));
		acc(0, EE_BASE, 1'b1);
		acc(0, 24'h010000, 1'b0);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// whole run needs about 350 cycles
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
	initial begin
		t_start(1'b1, EMU_ONE_K, MODE_SYSTEM);
		t_system();
		t_user();
		t_vectors();
		t_options();
		t_test();
		wrap_up();
	end
endmodule
`default_nettype wire
